// *** timer_blocks.sv ***
/*
 * four timed function blocks: on/off delay, one-shot, toggle latch and
 * blinker, with time parameters and running values behind a register bus.
 * assumes trigger and reset pins synchronous to core_clk_in, and srst_in
 * as the power-on reset.
 */
// Behaviour
// RULE1 - trigger rising starts the high-going delay timing
// RULE2 - trigger falling starts the low-going delay timing
// RULE3 - delay reset clears timer and output, beating the trigger
// RULE4 - trigger held high through high delay sets delay output
// RULE5 - trigger dropping early abandons high delay, output stays low
// RULE6 - trigger held low through low delay clears delay output
// RULE7 - trigger rising early abandons low delay, output stays high
// RULE8 - times held as hours, minutes, seconds, ms, up to 999:59:59.990
// RULE9 - each timed block shows its elapsed time as a running value
// RULE10 - one-shot rising edge gives a pulse of configured width
// RULE11 - one-shot ignores trigger while its output is high
// RULE12 - one-shot reset forces output low and clears the timer
// RULE13 - optional retentive one-shot keeps timer state through reset
// RULE14 - toggle latch inverts output on each trigger rising edge
// RULE15 - toggle reset forces output low, beating a trigger edge
// RULE16 - toggle latch output starts at zero after power-up
// RULE17 - toggle trigger already high at start counts as an edge
// RULE18 - blinker held trigger gives high time then low time, repeating
// RULE19 - blinker stops with output low while trigger is low
// RULE20 - blinker reset holds output low; release resumes by trigger level
// RULE21 - blinker has separate high and low time parameters
// RULE22 - all timers count a shared millisecond tick against parameters
// RULE23 - one-shot reset beats a same-cycle trigger edge
`timescale 1ns/1ps
module timer_blocks import timer_blocks_pkg::*; #(
	parameter int unsigned TICKS = TICK_CYCLES
) (
	input  wire logic        core_clk_in,
	input  wire logic        srst_in,
	input  wire bus_req_s    bus_req_in,
	output bus_rsp_s         bus_rsp_out,
	input  wire logic [3:0]  trg_in,
	input  wire logic [3:0]  rst_in,
	input  wire logic        retain_en_in,
	output logic [3:0]       q_out,
	output logic [31:0]      dly_run_out,
	output logic [31:0]      pulse_run_out,
	output logic [31:0]      blink_run_out
);
	logic        tick;
	logic [3:0]  trg_prev_r;
	logic [3:0]  rise;
	logic [31:0] param_r [NUM_PAR];

	// rule 22 shared tick
	// RULE22 common ms tick
	ms_tick_gen #(
		.TICKS (TICKS)
	) u_tick (
		.core_clk_in (core_clk_in),
		.srst_in     (srst_in),
		.tick_out    (tick)
	);

	// previous levels reset to zero, so a high level at start is an edge
	// RULE17 start level edge
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			trg_prev_r <= 4'h0;
		end else begin
			trg_prev_r <= trg_in;
		end
	end
	assign rise = trg_in & ~trg_prev_r;

	// ---- register bus slave ----
	wire       setup_ph = bus_req_in.psel && !bus_req_in.penable;
	wire       access   = bus_req_in.psel && bus_req_in.penable;
	wire [7:0] addr     = bus_req_in.paddr;
	wire [7:0] par_off  = addr - OFS_PAR_BASE;
	wire       hit_par  = (addr >= OFS_PAR_BASE) && (addr < OFS_RUN_DLY)
	                      && (addr[1:0] == 2'b00);
	wire [2:0] par_idx  = par_off[4:2];
	wire       hit_stat = (addr == OFS_STATUS);
	wire       hit_rdly = (addr == OFS_RUN_DLY);
	wire       hit_rpls = (addr == OFS_RUN_PULSE);
	wire       hit_rblk = (addr == OFS_RUN_BLINK);
	wire       addr_ok  = hit_par || hit_stat || hit_rdly || hit_rpls || hit_rblk;
	wire       wr_en    = access && bus_req_in.pwrite && hit_par;

	wire [31:0] status_word = {24'h000000, trg_in, q_out};
	wire [31:0] rd_mux = hit_stat ? status_word :
	                     hit_par  ? param_r[par_idx] :
	                     hit_rdly ? dly_run_out :
	                     hit_rpls ? pulse_run_out :
	                     hit_rblk ? blink_run_out : 32'h00000000;

	logic [31:0] prdata_r;

	// read data caught in the setup cycle, shown in the access cycle
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			prdata_r <= '0;
		end else if (setup_ph) begin
			prdata_r <= rd_mux;
		end
	end

	// RULE8 clamped time fields
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			for (int i = 0; i < NUM_PAR; i++) begin
				param_r[i] <= PARAM_RST;
			end
		end else if (wr_en) begin
			param_r[par_idx] <= clamp_time(bus_req_in.pwdata);
		end
	end

	assign bus_rsp_out = '{
		prdata:  prdata_r,
		pready:  1'b1,
		pslverr: access && !addr_ok
	};

	// ---- on/off delay ----
	dly_state_e  dly_st_r;
	dly_state_e  dly_st_nxt;
	logic        dly_done;
	wire         dly_timing = (dly_st_r == DLY_RISE) || (dly_st_r == DLY_FALL);
	wire  [31:0] dly_target = time_to_ms((dly_st_r == DLY_RISE) ?
	                          param_r[PAR_DLY_HIGH] : param_r[PAR_DLY_LOW]);

	always_comb begin
		dly_st_nxt = dly_st_r;
		case (dly_st_r)
			// RULE1 start high timing
			DLY_LOW: dly_st_nxt = trg_in[BLK_DLY] ? DLY_RISE : DLY_LOW;
			// RULE4 RULE5 finish or abandon
			DLY_RISE: begin
				if (!trg_in[BLK_DLY]) begin
					dly_st_nxt = DLY_LOW;
				end else if (dly_done) begin
					dly_st_nxt = DLY_HIGH;
				end
			end
			// RULE2 start low timing
			DLY_HIGH: dly_st_nxt = trg_in[BLK_DLY] ? DLY_HIGH : DLY_FALL;
			// RULE6 RULE7 finish or abandon
			DLY_FALL: begin
				if (trg_in[BLK_DLY]) begin
					dly_st_nxt = DLY_HIGH;
				end else if (dly_done) begin
					dly_st_nxt = DLY_LOW;
				end
			end
			default: dly_st_nxt = DLY_LOW;
		endcase
	end

	// RULE3 reset beats trigger
	always_ff @(posedge core_clk_in) begin
		if (srst_in || rst_in[BLK_DLY]) begin
			dly_st_r <= DLY_LOW;
		end else begin
			dly_st_r <= dly_st_nxt;
		end
	end

	// RULE9 delay running value
	elapsed_counter u_dly_cnt (
		.core_clk_in (core_clk_in),
		.srst_in     (srst_in),
		.clr_in      (rst_in[BLK_DLY] || !dly_timing),
		.run_in      (dly_timing),
		.tick_in     (tick),
		.target_in   (dly_target),
		.count_out   (dly_run_out),
		.done_out    (dly_done)
	);

	// ---- one-shot ----
	logic pulse_q_r;
	logic pulse_done;
	wire  pulse_srst = srst_in && !retain_en_in;
	wire  pulse_start = rise[BLK_PULSE] && !pulse_q_r;

	// RULE13 retentive keeps state
	// RULE12 RULE23 reset wins
	// RULE10 RULE11 pulse without retrigger
	always_ff @(posedge core_clk_in) begin
		if (pulse_srst || rst_in[BLK_PULSE]) begin
			pulse_q_r <= 1'b0;
		end else if (pulse_start) begin
			pulse_q_r <= 1'b1;
		end else if (pulse_q_r && pulse_done) begin
			pulse_q_r <= 1'b0;
		end
	end

	// RULE9 pulse running value
	elapsed_counter u_pulse_cnt (
		.core_clk_in (core_clk_in),
		.srst_in     (pulse_srst),
		.clr_in      (rst_in[BLK_PULSE] || !pulse_q_r),
		.run_in      (pulse_q_r),
		.tick_in     (tick),
		.target_in   (time_to_ms(param_r[PAR_PULSE_W])),
		.count_out   (pulse_run_out),
		.done_out    (pulse_done)
	);

	// ---- toggle latch ----
	logic tog_q_r;

	// RULE16 RULE15 RULE14 toggle with reset
	always_ff @(posedge core_clk_in) begin
		if (srst_in || rst_in[BLK_TOG]) begin
			tog_q_r <= 1'b0;
		end else if (rise[BLK_TOG]) begin
			tog_q_r <= !tog_q_r;
		end
	end

	// ---- blinker ----
	blink_state_e blk_st_r;
	blink_state_e blk_st_nxt;
	logic         blk_done;
	wire          blk_trg = trg_in[BLK_BLINK];
	// RULE21 separate phase times
	wire   [31:0] blk_target = time_to_ms((blk_st_r == BLK_ON) ?
	                           param_r[PAR_BLK_HIGH] : param_r[PAR_BLK_LOW]);

	always_comb begin
		blk_st_nxt = blk_st_r;
		case (blk_st_r)
			// RULE20 resume by level
			BLK_OFF: blk_st_nxt = blk_trg ? BLK_ON : BLK_OFF;
			// RULE18 RULE19 cycle or stop
			BLK_ON: begin
				if (!blk_trg) begin
					blk_st_nxt = BLK_OFF;
				end else if (blk_done) begin
					blk_st_nxt = BLK_GAP;
				end
			end
			BLK_GAP: begin
				if (!blk_trg) begin
					blk_st_nxt = BLK_OFF;
				end else if (blk_done) begin
					blk_st_nxt = BLK_ON;
				end
			end
			default: blk_st_nxt = BLK_OFF;
		endcase
	end

	// RULE20 reset holds low
	always_ff @(posedge core_clk_in) begin
		if (srst_in || rst_in[BLK_BLINK]) begin
			blk_st_r <= BLK_OFF;
		end else begin
			blk_st_r <= blk_st_nxt;
		end
	end

	// RULE9 blink running value
	elapsed_counter u_blk_cnt (
		.core_clk_in (core_clk_in),
		.srst_in     (srst_in),
		.clr_in      (rst_in[BLK_BLINK] || blk_st_nxt != blk_st_r
		              || blk_st_r == BLK_OFF),
		.run_in      (blk_st_r != BLK_OFF),
		.tick_in     (tick),
		.target_in   (blk_target),
		.count_out   (blink_run_out),
		.done_out    (blk_done)
	);

	// outputs straight from state flip-flops
	assign q_out = {
		blk_st_r[0],
		tog_q_r,
		pulse_q_r,
		dly_st_r[0]
	};

	// ---- checks ----
	property p_dly_rst;
		@(posedge core_clk_in) disable iff (srst_in)
		rst_in[BLK_DLY] |=> !q_out[BLK_DLY] && dly_run_out == 32'h00000000;
	endproperty
	a_dly_rst: assert property (p_dly_rst) // RULE3
		else $error("delay reset did not clear output and timer");

	property p_dly_rise;
		@(posedge core_clk_in) disable iff (srst_in)
		$rose(q_out[BLK_DLY]) |-> $past(trg_in[BLK_DLY]) && $past(dly_done);
	endproperty
	a_dly_rise: assert property (p_dly_rise) // RULE4
		else $error("delay output rose without expired high time");

	property p_dly_abandon;
		@(posedge core_clk_in) disable iff (srst_in)
		(dly_st_r == DLY_RISE && !trg_in[BLK_DLY] && !rst_in[BLK_DLY])
		|=> dly_st_r == DLY_LOW && !q_out[BLK_DLY] ##1 dly_run_out == 32'h00000000;
	endproperty
	a_dly_abandon: assert property (p_dly_abandon) // RULE5
		else $error("early drop did not abandon high delay");

	property p_dly_keep;
		@(posedge core_clk_in) disable iff (srst_in)
		(dly_st_r == DLY_FALL && trg_in[BLK_DLY] && !rst_in[BLK_DLY])
		|=> q_out[BLK_DLY] && dly_st_r == DLY_HIGH;
	endproperty
	a_dly_keep: assert property (p_dly_keep) // RULE7
		else $error("early rise did not keep delay output high");

	property p_pulse_start;
		@(posedge core_clk_in) disable iff (srst_in)
		(pulse_start && !rst_in[BLK_PULSE])
		|=> pulse_q_r && pulse_run_out == 32'h00000000;
	endproperty
	a_pulse_start: assert property (p_pulse_start) // RULE10
		else $error("one-shot did not start its pulse");

	property p_pulse_hold;
		@(posedge core_clk_in) disable iff (srst_in)
		(pulse_q_r && !pulse_done && !rst_in[BLK_PULSE])
		|=> pulse_q_r && pulse_run_out >= $past(pulse_run_out);
	endproperty
	a_pulse_hold: assert property (p_pulse_hold) // RULE11
		else $error("one-shot pulse was cut or restarted");

	property p_pulse_rst;
		@(posedge core_clk_in) disable iff (srst_in)
		rst_in[BLK_PULSE] |=> !pulse_q_r && pulse_run_out == 32'h00000000;
	endproperty
	a_pulse_rst: assert property (p_pulse_rst) // RULE12
		else $error("one-shot reset did not clear pulse");

	property p_tog_flip;
		@(posedge core_clk_in) disable iff (srst_in)
		(rise[BLK_TOG] && !rst_in[BLK_TOG]) |=> tog_q_r != $past(tog_q_r);
	endproperty
	a_tog_flip: assert property (p_tog_flip) // RULE14
		else $error("toggle latch did not invert");

	property p_tog_rst;
		@(posedge core_clk_in) disable iff (srst_in)
		rst_in[BLK_TOG] |=> !tog_q_r;
	endproperty
	a_tog_rst: assert property (p_tog_rst) // RULE15
		else $error("toggle reset did not clear output");

	property p_blk_stop;
		@(posedge core_clk_in) disable iff (srst_in)
		(!blk_trg || rst_in[BLK_BLINK]) |=> !q_out[BLK_BLINK];
	endproperty
	a_blk_stop: assert property (p_blk_stop) // RULE19
		else $error("blinker output high with trigger low or reset");

	c_dly_high: cover property (@(posedge core_clk_in) $rose(q_out[BLK_DLY]));
	c_pulse_end: cover property (@(posedge core_clk_in) $fell(pulse_q_r));
	c_blk_gap: cover property (@(posedge core_clk_in) blk_st_r == BLK_GAP);
	c_tog_flip: cover property (@(posedge core_clk_in) $rose(tog_q_r));
endmodule : timer_blocks

// *** timer_blocks_pkg.sv ***
/*
 * constants, carrier structs, state codes and time helpers for the
 * timed function blocks. assumes a 20 MHz core clock and register bus access.
 */
package timer_blocks_pkg;

	// clock and tick timing
	localparam int unsigned CLK_PERIOD_NS  = 50;
	localparam int unsigned TICK_PERIOD_NS = 1000000;
	localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] OFS_STATUS    = 8'h00;
	localparam logic [7:0] OFS_PAR_BASE  = 8'h04;
	localparam logic [7:0] OFS_RUN_DLY   = 8'h18;
	localparam logic [7:0] OFS_RUN_PULSE = 8'h1c;
	localparam logic [7:0] OFS_RUN_BLINK = 8'h20;

	// time parameter slots, at OFS_PAR_BASE + 4 * index
	localparam int unsigned NUM_PAR       = 5;
	localparam int unsigned PAR_DLY_HIGH  = 0;
	localparam int unsigned PAR_DLY_LOW   = 1;
	localparam int unsigned PAR_PULSE_W   = 2;
	localparam int unsigned PAR_BLK_HIGH  = 3;
	localparam int unsigned PAR_BLK_LOW   = 4;
	localparam logic [31:0] PARAM_RST     = 32'h0000000a;

	// block positions in q and status vectors
	localparam int unsigned BLK_DLY   = 0;
	localparam int unsigned BLK_PULSE = 1;
	localparam int unsigned BLK_TOG   = 2;
	localparam int unsigned BLK_BLINK = 3;
	localparam int unsigned STAT_TRG_LSB = 4;

	// time field layout: hours, minutes, seconds, milliseconds
	localparam int unsigned HOUR_LSB = 22;
	localparam int unsigned MIN_LSB  = 16;
	localparam int unsigned SEC_LSB  = 10;
	localparam logic [9:0]  HOUR_MAX = 10'h3e7;
	localparam logic [5:0]  MIN_MAX  = 6'h3b;
	localparam logic [5:0]  SEC_MAX  = 6'h3b;
	localparam logic [9:0]  MS_MAX   = 10'h3de;
	localparam logic [9:0]  MS_MIN   = 10'h00a;
	localparam logic [31:0] MS_PER_HOUR = 32'h0036ee80;
	localparam logic [31:0] MS_PER_MIN  = 32'h0000ea60;
	localparam logic [31:0] MS_PER_SEC  = 32'h000003e8;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} bus_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} bus_rsp_s;

	typedef enum logic [1:0] {
		DLY_LOW  = 2'b00,
		DLY_HIGH = 2'b01,
		DLY_RISE = 2'b10,
		DLY_FALL = 2'b11
	} dly_state_e;

	typedef enum logic [1:0] {
		BLK_OFF  = 2'b00,
		BLK_ON   = 2'b01,
		BLK_GAP  = 2'b10
	} blink_state_e;

	// keep each field inside its range, never below the least time
	function automatic logic [31:0] clamp_time(input logic [31:0] w);
		logic [9:0] h;
		logic [5:0] m;
		logic [5:0] s;
		logic [9:0] ms;
		h  = (w[31:22] > HOUR_MAX) ? HOUR_MAX : w[31:22];
		m  = (w[21:16] > MIN_MAX) ? MIN_MAX : w[21:16];
		s  = (w[15:10] > SEC_MAX) ? SEC_MAX : w[15:10];
		ms = (w[9:0] > MS_MAX) ? MS_MAX : w[9:0];
		if (h == 10'h000 && m == 6'h00 && s == 6'h00 && ms < MS_MIN) begin
			ms = MS_MIN;
		end
		return {h, m, s, ms};
	endfunction : clamp_time

	function automatic logic [31:0] time_to_ms(input logic [31:0] w);
		logic [31:0] hp;
		logic [31:0] mp;
		logic [31:0] sp;
		hp = 32'(w[31:22]) * MS_PER_HOUR;
		mp = 32'(w[21:16]) * MS_PER_MIN;
		sp = 32'(w[15:10]) * MS_PER_SEC;
		return hp + mp + sp + 32'(w[9:0]);
	endfunction : time_to_ms

endpackage : timer_blocks_pkg

// *** ms_tick_gen.sv ***
/*
 * millisecond tick divider: one-cycle enable every TICK_CYCLES clocks.
 * assumes a free-running core clock.
 */
`timescale 1ns/1ps
module ms_tick_gen import timer_blocks_pkg::*; #(
	parameter int unsigned TICKS = TICK_CYCLES
) (
	input  wire logic core_clk_in,
	input  wire logic srst_in,
	output logic      tick_out
);
	localparam int unsigned CW = (TICKS > 2) ? $clog2(TICKS) : 1;
	localparam logic [CW-1:0] LAST = CW'(TICKS - 1);

	if (TICKS < 2) begin : g_chk
		$error("ms_tick_gen needs at least two cycles per tick");
	end

	logic [CW-1:0] div_r;
	logic          tick_r;

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			div_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			div_r  <= (div_r == LAST) ? '0 : div_r + 1'b1;
			tick_r <= (div_r == LAST);
		end
	end

	assign tick_out = tick_r;
endmodule : ms_tick_gen

// *** elapsed_counter.sv ***
/*
 * saturating elapsed-millisecond counter with clear and compare.
 * assumes a one-cycle tick enable from the divider.
 */
`timescale 1ns/1ps
module elapsed_counter import timer_blocks_pkg::*; (
	input  wire logic        core_clk_in,
	input  wire logic        srst_in,
	input  wire logic        clr_in,
	input  wire logic        run_in,
	input  wire logic        tick_in,
	input  wire logic [31:0] target_in,
	output logic [31:0]      count_out,
	output logic             done_out
);
	logic [31:0] cnt_r;

	always_ff @(posedge core_clk_in) begin
		if (srst_in || clr_in) begin
			cnt_r <= '0;
		end else if (run_in && tick_in && cnt_r != 32'hffffffff) begin
			cnt_r <= cnt_r + 32'h00000001;
		end
	end

	assign count_out = cnt_r;
	assign done_out  = (cnt_r >= target_in);
endmodule : elapsed_counter

// *** timer_blocks_tb_top.sv ***
/*
 * self-checking bench for timer_blocks: register bus access, then each
 * timed block driven through its trigger and reset pins.
 * assumes a short tick (TK clocks per ms) and a bus that answers with pready.
 */
`timescale 1ns/1ps
module timer_blocks_tb_top import timer_blocks_pkg::*; ;

	localparam int TK    = 4;
	localparam int LIMIT = 20000;

	logic        core_clk_in;
	logic        srst_in;
	logic        retain_en_in;
	bus_req_s    req;
	bus_rsp_s    rsp;
	logic [3:0]  trg;
	logic [3:0]  rst;
	logic [3:0]  q;
	logic [31:0] drun;
	logic [31:0] prun;
	logic [31:0] brun;
	logic [31:0] rd;
	logic        er;
	int          mismatches;
	int          n_checks;
	int          cycles = 0;

	timer_blocks #(.TICKS(TK)) timer_blocks_inst (
		.core_clk_in   (core_clk_in),
		.srst_in       (srst_in),
		.bus_req_in    (req),
		.bus_rsp_out   (rsp),
		.trg_in        (trg),
		.rst_in        (rst),
		.retain_en_in  (retain_en_in),
		.q_out         (q),
		.dly_run_out   (drun),
		.pulse_run_out (prun),
		.blink_run_out (brun)
	);

	initial begin
		core_clk_in = 1'b0;
		forever #25 core_clk_in = ~core_clk_in;
	end

	function automatic int lo(input int t);
		return (t - 1) * TK;
	endfunction : lo

	function automatic int hi(input int t);
		return (t + 1) * TK + 4;
	endfunction : hi

	task automatic stop_test();
		if (mismatches == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic chk_rng(input string nm, input int l, input int h, input int got);
		n_checks++;
		if (got < l || got > h) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, l, h, got);
		end
	endtask : chk_rng

	task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge core_clk_in);
		req.penable <= 1'b1;
		do begin
			@(posedge core_clk_in);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask : bus_xfer

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
		bus_xfer(1'b0, a, 32'h00000000);
		chk("prdata", exp, rd);
		chk("pslverr", 32'(experr), 32'(er));
	endtask : rdchk

	task automatic prm(input int idx, input logic [31:0] v);
		bus_xfer(1'b1, OFS_PAR_BASE + 8'(4 * idx), v);
	endtask : prm

	task automatic pin(input logic [3:0] t, input logic [3:0] r);
		@(posedge core_clk_in);
		trg <= t;
		rst <= r;
	endtask : pin

	task automatic wait_q(input int idx, input logic v, input int l, input int h);
		int n;
		n = 0;
		while (q[idx] !== v && n < h + 2) begin
			@(posedge core_clk_in);
			#1;
			n++;
		end
		chk_rng("q_out change", l, h, n);
	endtask : wait_q

	task automatic hold_q(input int idx, input logic v, input int c);
		int bad;
		bad = 0;
		repeat (c) begin
			@(posedge core_clk_in);
			#1;
			if (q[idx] !== v) bad++;
		end
		chk("q_out hold", 32'h00000000, 32'(bad));
	endtask : hold_q

	task automatic do_reset(input int c);
		@(posedge core_clk_in);
		srst_in <= 1'b1;
		repeat (c) @(posedge core_clk_in);
		srst_in <= 1'b0;
	endtask : do_reset

	always @(posedge core_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			mismatches++;
			stop_test();
		end
	end

	initial begin
		srst_in = 1'b1;
		retain_en_in = 1'b0;
		req = '0;
		trg = 4'h0;
		rst = 4'h0;
		mismatches = 0;
		n_checks = 0;
		do_reset(10);
		@(posedge core_clk_in);
		#1;
		chk("q_out reset", 32'h00000000, 32'(q));
		rdchk(OFS_PAR_BASE, PARAM_RST, 1'b0);
		rdchk(OFS_STATUS, 32'h00000000, 1'b0);
		rdchk(8'hfc, 32'h00000000, 1'b1);
		bus_xfer(1'b1, OFS_PAR_BASE, 32'hffffffff);
		rdchk(OFS_PAR_BASE, {HOUR_MAX, MIN_MAX, SEC_MAX, MS_MAX}, 1'b0);
		bus_xfer(1'b1, OFS_PAR_BASE, 32'h00000000);
		rdchk(OFS_PAR_BASE, 32'(MS_MIN), 1'b0);
		bus_xfer(1'b1, OFS_RUN_DLY, 32'h00000005);
		rdchk(OFS_RUN_DLY, 32'h00000000, 1'b0);
		prm(PAR_DLY_HIGH, 32'h00000014);
		prm(PAR_DLY_LOW, 32'h0000000a);
		prm(PAR_PULSE_W, 32'h0000000a);
		// on/off delay
		pin(4'h1, 4'h0);
		repeat (5 * TK) @(posedge core_clk_in);
		#1;
		chk_rng("dly_run_out", 3, 6, int'(drun));
		pin(4'h0, 4'h0);
		hold_q(0, 1'b0, 30 * TK);
		chk("dly_run_out idle", 32'h00000000, drun);
		pin(4'h1, 4'h0);
		wait_q(0, 1'b1, lo(20), hi(20));
		pin(4'h0, 4'h0);
		repeat (5 * TK) @(posedge core_clk_in);
		pin(4'h1, 4'h0);
		hold_q(0, 1'b1, 15 * TK);
		pin(4'h0, 4'h0);
		wait_q(0, 1'b0, lo(10), hi(10));
		pin(4'h1, 4'h0);
		wait_q(0, 1'b1, lo(20), hi(20));
		pin(4'h1, 4'h1);
		wait_q(0, 1'b0, 1, 2);
		hold_q(0, 1'b0, 25 * TK);
		chk("dly_run_out reset", 32'h00000000, drun);
		// one-shot, second edge in mid-pulse
		pin(4'h2, 4'h0);
		wait_q(1, 1'b1, 1, 2);
		repeat (5 * TK) @(posedge core_clk_in);
		#1;
		chk_rng("pulse_run_out", 3, 6, int'(prun));
		pin(4'h0, 4'h0);
		pin(4'h2, 4'h0);
		wait_q(1, 1'b0, lo(10) - 5 * TK - 2, hi(10) - 5 * TK);
		pin(4'h0, 4'h0);
		pin(4'h2, 4'h0);
		wait_q(1, 1'b1, 1, 2);
		repeat (2 * TK) @(posedge core_clk_in);
		pin(4'h2, 4'h2);
		wait_q(1, 1'b0, 1, 2);
		@(posedge core_clk_in);
		#1;
		chk("pulse_run_out reset", 32'h00000000, prun);
		rdchk(OFS_RUN_PULSE, 32'h00000000, 1'b0);
		pin(4'h0, 4'h0);
		pin(4'h2, 4'h2);
		hold_q(1, 1'b0, 4);
		pin(4'h0, 4'h0);
		// toggle latch
		pin(4'h4, 4'h0);
		wait_q(2, 1'b1, 1, 2);
		pin(4'h0, 4'h0);
		pin(4'h4, 4'h0);
		wait_q(2, 1'b0, 1, 2);
		pin(4'h0, 4'h0);
		pin(4'h4, 4'h0);
		wait_q(2, 1'b1, 1, 2);
		rdchk(OFS_STATUS, 32'h00000044, 1'b0);
		pin(4'h0, 4'h0);
		pin(4'h4, 4'h4);
		wait_q(2, 1'b0, 1, 2);
		pin(4'h0, 4'h0);
		pin(4'h4, 4'h4);
		hold_q(2, 1'b0, 4);
		pin(4'h0, 4'h0);
		// retentive pulse across reset, toggle trigger high at start
		@(posedge core_clk_in);
		retain_en_in <= 1'b1;
		pin(4'h6, 4'h0);
		wait_q(1, 1'b1, 1, 2);
		do_reset(2);
		@(posedge core_clk_in);
		#1;
		chk("pulse kept", 32'h00000001, 32'(q[1]));
		wait_q(2, 1'b1, 0, 3);
		@(posedge core_clk_in);
		retain_en_in <= 1'b0;
		pin(4'h0, 4'h0);
		// blinker
		prm(PAR_BLK_HIGH, 32'h0000000a);
		prm(PAR_BLK_LOW, 32'h00000014);
		pin(4'h8, 4'h0);
		wait_q(3, 1'b1, 1, 2);
		wait_q(3, 1'b0, lo(10), hi(10));
		wait_q(3, 1'b1, lo(20), hi(20));
		wait_q(3, 1'b0, lo(10), hi(10));
		pin(4'h8, 4'h0);
		wait_q(3, 1'b1, lo(20), hi(20));
		pin(4'h0, 4'h0);
		wait_q(3, 1'b0, 1, 2);
		hold_q(3, 1'b0, 25 * TK);
		pin(4'h8, 4'h8);
		hold_q(3, 1'b0, 15 * TK);
		chk("blink_run_out reset", 32'h00000000, brun);
		rdchk(OFS_RUN_BLINK, 32'h00000000, 1'b0);
		pin(4'h8, 4'h0);
		wait_q(3, 1'b1, 1, 2);
		repeat (5 * TK) @(posedge core_clk_in);
		#1;
		chk_rng("blink_run_out", 3, 6, int'(brun));
		stop_test();
	end

endmodule : timer_blocks_tb_top
